// [common/wdt_pkg.sv]
// package: register map, field positions and reset values of the watchdog
package wdt_pkg;
  localparam int unsigned addr_w = 12;
  localparam logic [11:0] off_load = 12'h000;
  localparam logic [11:0] off_value = 12'h004;
  localparam logic [11:0] off_ctrl = 12'h008;
  localparam logic [11:0] off_lock = 12'h00c;
  localparam logic [11:0] off_ris = 12'h010;
  localparam logic [11:0] off_imask = 12'h014;
  localparam logic [11:0] off_mis = 12'h018;
  // control field positions
  localparam int unsigned ctl_cnt_en = 0;
  localparam int unsigned ctl_int_en = 1;
  localparam int unsigned ctl_rst_en = 2;
  localparam int unsigned ctl_stall = 3;
  // status field positions
  localparam int unsigned st_timeout = 0;
  localparam int unsigned st_sysrst = 1;
  localparam int unsigned n_events = 2;
  // writing this word to the lock register releases the lock; anything else engages it
  localparam logic [31:0] unlock_key = 32'h0000_a5a5;
  localparam logic [31:0] load_reset = 32'hffff_ffff;
  localparam logic [3:0] ctrl_reset = 4'h0;
  localparam logic [n_events-1:0] mask_reset = 2'h3;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_armed = 2'b01,
    st_warned = 2'b11,
    st_fired = 2'b10
  } wd_state_t;
endpackage

// [verilog/wdt_counter.sv]
// 32-bit down counter with load, stall and zero detect
module wdt_counter #(
  parameter int unsigned width = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic stall,
  input wire logic load,
  input wire logic [width-1:0] load_value,
  // status
  output logic [width-1:0] count,
  output logic zero_hit
);
  logic [width-1:0] count_q;
  logic [width-1:0] count_d;
  logic hit_d;

  // the zero flag ignores load, so the parent can feed it straight back as a reload
  assign hit_d = run && !stall && (count_q == '0);

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (run && !stall && !hit_d) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= wdt_pkg::load_reset;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
  assign zero_hit = hit_d;
endmodule

// [verilog/wdt_top.sv]
// watchdog timer with apb registers, lock, debug stall and two-stage expiry
// Contract
// - The timeout counter is a 32-bit down counter loaded from the load register.
// - The first zero of the enabled counter raises the timeout interrupt and reloads the count.
// - A second zero with the timeout still pending and reset enabled asserts system reset.
// - Clearing the pending timeout before the second zero reloads the counter and resumes.
// - Software can read back the programmed load value.
// - A load write while running goes into the counter at once.
// - Writing a load value of zero raises the timeout interrupt at once.
// - While locked, writes to load value and the enable bits are ignored.
// - Unlocking restores write access to the configuration registers.
// - Reset enable allows the second-timeout reset; when clear no reset is issued.
// - With stall enabled the counter freezes while the processor is debug-halted.
// - With stall disabled the counter keeps running through a debug halt.
// - Software can read whether the counter has been enabled.
// - Software can read the present count at any time.
//
// Local design decisions: the placing of the registers and the APB register port.
module wdt_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system
  input wire logic debug_halt,
  output logic irq,
  output logic sys_reset
);
  // configuration registers
  logic [31:0] load_q;
  logic [31:0] load_d;
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic lock_q;
  logic lock_d;
  logic [wdt_pkg::n_events-1:0] mask_q;
  logic [wdt_pkg::n_events-1:0] mask_d;

  // status bits and expiry sequence
  logic [wdt_pkg::n_events-1:0] ris_q;
  logic [wdt_pkg::n_events-1:0] ris_d;
  logic [wdt_pkg::n_events-1:0] ris_set;
  logic [wdt_pkg::n_events-1:0] ris_clr;
  logic rst_q;
  logic rst_d;
  wdt_pkg::wd_state_t state_q;
  wdt_pkg::wd_state_t state_d;

  // bus side
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic load_wr;

  // counter side
  logic ld;
  logic [31:0] ld_value;
  logic cnt_run;
  logic cnt_stall;
  logic zero_hit;
  logic timeout_set;
  logic cleared;
  logic [31:0] count;

  // each transfer is decided in its setup cycle; pready is tied high, so the access
  // phase that follows always completes at the next edge
  assign setup = psel && !penable;
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;

  // address decode for the error flag; anything off the map answers with an error
  always_comb begin
    case (paddr)
      wdt_pkg::off_load,
      wdt_pkg::off_value,
      wdt_pkg::off_ctrl,
      wdt_pkg::off_lock,
      wdt_pkg::off_ris,
      wdt_pkg::off_imask,
      wdt_pkg::off_mis: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // a load write that the lock lets through
  assign load_wr = wr && (paddr == wdt_pkg::off_load) && !lock_q;
  // a write of one to the pending timeout bit; only a set bit counts as a clear
  assign cleared = wr && (paddr == wdt_pkg::off_ris) && pwdata[wdt_pkg::st_timeout]
    && ris_q[wdt_pkg::st_timeout];

  // the counter reloads on a load write, on every zero and on a timeout clear; the load
  // write wins the value mux, so a new value goes in at once even on the zero cycle
  // limitation: with a load value of zero the count sits at zero and expires every cycle
  assign ld = load_wr || zero_hit || cleared;
  assign ld_value = load_wr ? pwdata : load_q;
  assign cnt_run = ctrl_q[wdt_pkg::ctl_cnt_en];
  // a debug halt only freezes the count while stall is enabled
  assign cnt_stall = ctrl_q[wdt_pkg::ctl_stall] && debug_halt;

  wdt_counter #(.width(32)) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .run(cnt_run),
    .stall(cnt_stall),
    .load(ld),
    .load_value(ld_value),
    .count(count),
    .zero_hit(zero_hit)
  );

  // configuration writes take effect at the setup edge
  always_comb begin
    load_d = load_q;
    ctrl_d = ctrl_q;
    lock_d = lock_q;
    mask_d = mask_q;
    if (wr) begin
      case (paddr)
        wdt_pkg::off_load: begin
          if (!lock_q) begin
            load_d = pwdata;
          end
        end
        wdt_pkg::off_ctrl: begin
          if (!lock_q) begin
            // enabling the counter also enables the interrupt; neither can be turned off
            ctrl_d[wdt_pkg::ctl_cnt_en] = ctrl_q[wdt_pkg::ctl_cnt_en]
              | pwdata[wdt_pkg::ctl_cnt_en];
            ctrl_d[wdt_pkg::ctl_int_en] = ctrl_q[wdt_pkg::ctl_int_en]
              | pwdata[wdt_pkg::ctl_int_en] | pwdata[wdt_pkg::ctl_cnt_en];
            ctrl_d[wdt_pkg::ctl_rst_en] = pwdata[wdt_pkg::ctl_rst_en];
          end
          // stall is a debug convenience and stays writable under lock
          ctrl_d[wdt_pkg::ctl_stall] = pwdata[wdt_pkg::ctl_stall];
        end
        wdt_pkg::off_lock: begin
          // only the key opens the lock; any other word closes it again
          lock_d = (pwdata != wdt_pkg::unlock_key);
        end
        wdt_pkg::off_imask: begin
          mask_d = pwdata[wdt_pkg::n_events-1:0];
        end
        default: begin
          mask_d = mask_q;
        end
      endcase
    end
  end

  // the error flag is captured in the setup cycle and shown in the access phase
  always_comb begin
    err_d = err_q;
    if (setup) begin
      err_d = !mapped;
    end
  end

  // the first expiry and a zero load both raise the timeout
  assign timeout_set = (zero_hit && ctrl_q[wdt_pkg::ctl_int_en])
    || (load_wr && (pwdata == '0));

  // expiry sequence: armed until a timeout is pending, then a further zero fires reset if reset is enabled
  always_comb begin
    state_d = state_q;
    rst_d = rst_q;
    case (state_q)
      wdt_pkg::st_idle: begin
        if (ctrl_q[wdt_pkg::ctl_cnt_en]) begin
          state_d = wdt_pkg::st_armed;
        end
      end
      wdt_pkg::st_armed: begin
        if (ris_q[wdt_pkg::st_timeout] && !cleared) begin
          state_d = wdt_pkg::st_warned;
        end
      end
      wdt_pkg::st_warned: begin
        if (cleared) begin
          state_d = wdt_pkg::st_armed;
        end else if (zero_hit && ctrl_q[wdt_pkg::ctl_rst_en]) begin
          state_d = wdt_pkg::st_fired;
          rst_d = 1'b1;
        end
      end
      wdt_pkg::st_fired: begin
        // only presetn leaves this state, so software cannot cancel a reset once issued
        rst_d = 1'b1;
      end
      default: begin
        state_d = wdt_pkg::st_idle;
      end
    endcase
  end

  // status events and write-one-to-clear requests, one bit per event
  always_comb begin
    ris_set = '0;
    ris_clr = '0;
    ris_set[wdt_pkg::st_timeout] = timeout_set;
    ris_set[wdt_pkg::st_sysrst] = rst_d && !rst_q;
    if (wr && (paddr == wdt_pkg::off_ris)) begin
      ris_clr = pwdata[wdt_pkg::n_events-1:0];
    end
  end

  // sticky status bits: a set in the same cycle as a clear wins, so no event is lost
  for (genvar i = 0; i < wdt_pkg::n_events; i++) begin : g_status
    assign ris_d[i] = ris_set[i] | (ris_q[i] & ~ris_clr[i]);
  end

  // read mux; all reads stay open regardless of lock, and data holds until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd) begin
      rdata_d = '0;
      case (paddr)
        wdt_pkg::off_load: rdata_d = load_q;
        wdt_pkg::off_value: rdata_d = count;
        wdt_pkg::off_ctrl: rdata_d[3:0] = ctrl_q;
        wdt_pkg::off_lock: rdata_d[0] = lock_q;
        wdt_pkg::off_ris: rdata_d[wdt_pkg::n_events-1:0] = ris_q;
        wdt_pkg::off_imask: rdata_d[wdt_pkg::n_events-1:0] = mask_q;
        wdt_pkg::off_mis: rdata_d[wdt_pkg::n_events-1:0] = ris_q & mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // configuration group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q <= wdt_pkg::load_reset;
      ctrl_q <= wdt_pkg::ctrl_reset;
      lock_q <= 1'b0;
      mask_q <= wdt_pkg::mask_reset;
    end else begin
      load_q <= load_d;
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
      mask_q <= mask_d;
    end
  end

  // status and expiry group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_q <= '0;
      rst_q <= 1'b0;
      state_q <= wdt_pkg::st_idle;
    end else begin
      ris_q <= ris_d;
      rst_q <= rst_d;
      state_q <= state_d;
    end
  end

  // bus group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // the reset output latches until system reset; software cannot cancel it
  assign sys_reset = rst_q;
  // level interrupt: high while any unmasked status bit is set
  assign irq = |(ris_q & mask_q);
  // zero wait states: every access phase is the last one
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = psel && penable && err_q;
endmodule

// [sim/wdt_top_props.sv]
// port checker for the watchdog block
module wdt_top_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system
  input wire logic debug_halt,
  input wire logic irq,
  input wire logic sys_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bad_acc_s; psel && penable && paddr > 12'h018; endsequence
  sequence good_acc_s; psel && penable && paddr <= 12'h018 && paddr[1:0] == 2'b00; endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (bad_acc_s |-> pslverr) else $error("unmapped ok");
  a_err_mapped: assert property (good_acc_s |-> !pslverr) else $error("mapped error");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_rst_sticky: assert property (sys_reset |=> sys_reset) else $error("reset dropped");
  a_clean_start: assert property ($rose(presetn) |-> !irq && !sys_reset)
    else $error("outputs high after reset");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(psel && pwrite))
    else $error("irq fell without write");
endmodule
bind wdt_top wdt_top_props u_props (.*);

// [sim/wdt_sys_model.sv]
// debugger side: turns a halt request into the halt level seen by the watchdog
module wdt_sys_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // debugger control
  input wire logic halt_req,
  output logic debug_halt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_halt <= 1'b0;
    end else begin
      debug_halt <= halt_req;
    end
  end
endmodule

// [sim/watchdog_reload_lock_stall_tb.sv]
// self-checking bench for the watchdog block
module watchdog_reload_lock_stall_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sys_reset;
  logic halt_req, debug_halt, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v0;
  int failures, comparisons, n;
  wdt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_halt(debug_halt), .irq(irq), .sys_reset(sys_reset));
  wdt_sys_model u_sys (.pclk(pclk), .presetn(presetn), .halt_req(halt_req),
    .debug_halt(debug_halt));
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // polls raw status until the timeout bit shows
  task automatic wait_expiry();
    n = 0;
    do begin
      apb(1'b0, wdt_pkg::off_ris, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    chk({31'h0, rd[0]}, 32'h1);
    if (rd[0] !== 1'b1) begin
      wrap_up();
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, halt_req} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(wdt_pkg::off_load, wdt_pkg::load_reset);
    rdc(wdt_pkg::off_ctrl, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, wdt_pkg::off_ctrl, 32'h1);
    rdc(wdt_pkg::off_ctrl, 32'h3);
    apb(1'b1, wdt_pkg::off_load, 32'd100);
    apb(1'b0, wdt_pkg::off_value, 32'h0);
    chk({31'h0, rd <= 32'd100 && rd > 32'd90}, 32'h1);
    apb(1'b1, wdt_pkg::off_lock, 32'h1);
    rdc(wdt_pkg::off_lock, 32'h1);
    apb(1'b1, wdt_pkg::off_load, 32'd7);
    rdc(wdt_pkg::off_load, 32'd100);
    apb(1'b1, wdt_pkg::off_lock, wdt_pkg::unlock_key);
    apb(1'b1, wdt_pkg::off_load, 32'd40);
    rdc(wdt_pkg::off_load, 32'd40);
    wait_expiry();
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, wdt_pkg::off_ris, 32'h1);
    apb(1'b0, wdt_pkg::off_value, 32'h0);
    // a clear reloads to 40, so the read sees 38; without the reload it would be 34 or less
    chk({31'h0, rd <= 32'd40 && rd > 32'd35}, 32'h1);
    wait_expiry();
    // long enough for the second zero to pass with reset disabled
    repeat (50) @(posedge pclk);
    chk({31'h0, sys_reset}, 32'h0);
    rdc(wdt_pkg::off_ris, 32'h1);
    apb(1'b1, wdt_pkg::off_imask, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(wdt_pkg::off_mis, 32'h0);
    apb(1'b1, wdt_pkg::off_imask, 32'h3);
    apb(1'b1, wdt_pkg::off_ris, 32'h1);
    apb(1'b1, wdt_pkg::off_load, 32'd200);
    apb(1'b1, wdt_pkg::off_ctrl, 32'h8);
    halt_req <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, wdt_pkg::off_value, 32'h0);
    v0 = rd;
    repeat (10) @(posedge pclk);
    rdc(wdt_pkg::off_value, v0);
    apb(1'b1, wdt_pkg::off_ctrl, 32'h0);
    apb(1'b0, wdt_pkg::off_value, 32'h0);
    v0 = rd;
    rdc(wdt_pkg::off_value, v0 - 32'd3);
    halt_req <= 1'b0;
    apb(1'b1, wdt_pkg::off_load, 32'h0);
    rdc(wdt_pkg::off_ris, 32'h1);
    apb(1'b1, wdt_pkg::off_load, 32'd30);
    apb(1'b1, wdt_pkg::off_ctrl, 32'h4);
    n = 0;
    while (sys_reset !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, sys_reset}, 32'h1);
    rdc(wdt_pkg::off_ris, 32'h3);
    wrap_up();
  end
endmodule
